// File: hdl/cpdg_core.sv
/*
 * Parameter and diagnostic logic of a four-channel current-output module.
 * Holds the wire-break enables and range codes, scales each channel's
 * signed value to a current in microamps, and assembles the diagnostic
 * record read by the controller over a record-number access port.
 * Assumes: record port and channel values come from logic on MCLK;
 * wire-break and auxiliary-supply status arrive from the analog stage
 * asynchronously and are synchronised here.
 */
// Summary of operation
// - wire-break enable bits 0..3, upper reserved
// - range code FFh deactivates the channel
// - linear scaling, full scale 27648 or 16384
// - 0..20 mA ranges clamp negatives to zero
// - no interrupts; channel error lights LED, any error gets recorded
// - report parameter errors, wire breaks, aux loss
// - full record 01h, first four bytes 00h
// - summary byte error bits 0..4 and 7
// - descriptive bytes read as fixed constants
// - channel bytes, reserved zeros, timestamp
// - channel byte: bit0 parameter, bit4 wire break
// - channel summary bit n per channel
// - free microsecond counter, captured on events
`timescale 1ns/1ps
module cpdg_core (
    input  wire logic                  MCLK,
    input  wire logic                  RST_N,
    input  wire logic                  WR_STB,
    input  wire logic [7:0]            WR_REC,
    input  wire logic [4:0]            WR_IDX,
    input  wire logic [7:0]            WR_DATA,
    input  wire logic                  RD_STB,
    input  wire logic [7:0]            RD_REC,
    input  wire logic [4:0]            RD_IDX,
    input  wire logic [3:0][15:0]      CH_VALUE,
    input  wire logic [3:0]            WIRE_BREAK_RAW,
    input  wire logic                  AUX_OK_RAW,
    output logic      [7:0]            RD_DATA,
    output logic                       RD_VALID,
    output logic                       RD_ERR,
    output logic      [3:0][15:0]      CH_CURRENT_UA,
    output logic      [3:0]            CH_ACTIVE,
    output logic      [3:0]            CH_ERR_LED
);
    import cpdg_pkg::*;

    localparam int NUM_CH = 4;

    // scale a signed value to microamps for one range code
    function automatic logic [15:0] scale_ua(input logic [7:0] code, input logic signed [15:0] d);
        logic signed [31:0] dw;
        logic signed [31:0] r;
        dw = 32'(d);
        case (code)
            RNG_0_20_NEW: r = dw * SPAN_0_20_UA / FULL_NEW;
            RNG_0_20_OLD: r = dw * SPAN_0_20_UA / FULL_OLD;
            RNG_4_20_NEW: r = ZERO_4_20_UA + dw * SPAN_4_20_UA / FULL_NEW;
            RNG_4_20_OLD: r = ZERO_4_20_UA + dw * SPAN_4_20_UA / FULL_OLD;
            default:      r = 32'sd0;
        endcase
        // a current source cannot sink, so nothing goes below zero
        if (r < 32'sd0) begin
            r = 32'sd0;
        end
        return r[15:0];
    endfunction

    // true for any supported range code, deactivation included
    function automatic logic range_ok(input logic [7:0] code);
        return (code == RNG_0_20_NEW) || (code == RNG_0_20_OLD) || (code == RNG_4_20_NEW) ||
               (code == RNG_4_20_OLD) || (code == RNG_OFF);
    endfunction

    logic [3:0]       wbe_q;
    logic [3:0][7:0]  range_q;
    logic [3:0]       wb_s1_q;
    logic [3:0]       wb_s2_q;
    logic             aux_s1_q;
    logic             aux_s2_q;
    logic [3:0][7:0]  ch_err_q;
    logic [3:0][7:0]  ch_err_d;
    logic [7:0]       summary_q;
    logic [7:0]       summary_d;
    logic [3:0]       ch_sum_q;
    logic [5:0]       us_div_q;
    logic [31:0]      us_q;
    logic [31:0]      ts_q;
    logic             new_event;
    logic [7:0]       rd_byte;
    logic             rd_bad;

    // parameter writes; only the four enable bits are kept
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wbe_q <= WBE_RST[3:0];
        end else if (WR_STB && WR_REC == REC_HEAD && WR_IDX == PAR_IDX_WBE) begin
            wbe_q <= WR_DATA[3:0] & WBE_FIELD_MASK;
        end
    end

    // one range code per channel in records 80h..83h
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_range
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    range_q[c] <= RANGE_RST;
                end else if (WR_STB && WR_REC == REC_RANGE_BASE + 8'(c) && WR_IDX == PAR_IDX_RANGE) begin
                    range_q[c] <= WR_DATA;
                end
            end
        end
    endgenerate

    // two-flop synchronisers for the analog-stage status
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wb_s1_q  <= 4'h0;
            wb_s2_q  <= 4'h0;
            aux_s1_q <= 1'b1;
            aux_s2_q <= 1'b1;
        end else begin
            wb_s1_q  <= WIRE_BREAK_RAW;
            wb_s2_q  <= wb_s1_q;
            aux_s1_q <= AUX_OK_RAW;
            aux_s2_q <= aux_s1_q;
        end
    end

    // current drive; deactivated or misconfigured channels drive zero
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_drive
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    CH_CURRENT_UA[c] <= 16'h0000;
                    CH_ACTIVE[c]     <= 1'b0;
                end else begin
                    CH_CURRENT_UA[c] <= scale_ua(range_q[c], CH_VALUE[c]);
                    CH_ACTIVE[c]     <= range_q[c] != RNG_OFF && range_ok(range_q[c]);
                end
            end
        end
    endgenerate

    // error bytes rebuilt every cycle so they clear with the cause
    always_comb begin
        summary_d = 8'h00;
        for (int c = 0; c < NUM_CH; c++) begin
            ch_err_d[c] = 8'h00;
            ch_err_d[c][CHE_PARAM] = !range_ok(range_q[c]);
            // a disabled or deactivated channel never reports a break
            ch_err_d[c][CHE_WIRE]  = wbe_q[c] && wb_s2_q[c] && range_q[c] != RNG_OFF;
        end
        summary_d[SUM_PARAM]    = |{ch_err_d[3][CHE_PARAM], ch_err_d[2][CHE_PARAM],
                                    ch_err_d[1][CHE_PARAM], ch_err_d[0][CHE_PARAM]};
        summary_d[SUM_AUX]      = !aux_s2_q;
        summary_d[SUM_CHANNEL]  = |{ch_err_d[3], ch_err_d[2], ch_err_d[1], ch_err_d[0]};
        summary_d[SUM_EXTERNAL] = summary_d[SUM_AUX] ||
                                  |{ch_err_d[3][CHE_WIRE], ch_err_d[2][CHE_WIRE],
                                    ch_err_d[1][CHE_WIRE], ch_err_d[0][CHE_WIRE]};
        summary_d[SUM_INTERNAL] = 1'b0;
        summary_d[SUM_MODFAIL]  = summary_d[SUM_CHANNEL] || summary_d[SUM_EXTERNAL];
    end

    // a diagnostic event is any error bit rising
    assign new_event = |(summary_d & ~summary_q) || |(ch_err_d & ~ch_err_q);

    // registered error state, channel summary and LEDs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ch_err_q   <= '0;
            summary_q  <= 8'h00;
            ch_sum_q   <= 4'h0;
            CH_ERR_LED <= 4'h0;
        end else begin
            ch_err_q  <= ch_err_d;
            summary_q <= summary_d;
            for (int c = 0; c < NUM_CH; c++) begin
                ch_sum_q[c]   <= |ch_err_d[c];
                CH_ERR_LED[c] <= |ch_err_d[c];
            end
        end
    end

    // free-running microsecond counter, wraps after its top value
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            us_div_q <= 6'h00;
            us_q     <= 32'h00000000;
        end else if (us_div_q == 6'(US_CYCLES - 1)) begin
            us_div_q <= 6'h00;
            us_q     <= us_q + 32'h00000001;
        end else begin
            us_div_q <= us_div_q + 6'h01;
        end
    end

    // timestamp of the latest diagnostic event
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ts_q <= 32'h00000000;
        end else if (new_event) begin
            ts_q <= us_q;
        end
    end

    // read multiplexer; record 00h stops after the head bytes
    always_comb begin
        rd_byte = 8'h00;
        rd_bad  = 1'b0;
        if (RD_REC == REC_DIAG || (RD_REC == REC_HEAD && RD_IDX < DG_HEAD_LEN)) begin
            if (RD_IDX >= DG_TS_BASE && RD_IDX < DG_LEN) begin
                rd_byte = ts_q[8 * (RD_IDX - DG_TS_BASE) +: 8];
            end else if (RD_IDX >= DG_CH_BASE && RD_IDX < DG_RSV_BASE) begin
                rd_byte = ch_err_q[RD_IDX - DG_CH_BASE];
            end else if (RD_IDX >= DG_RSV_BASE && RD_IDX < DG_TS_BASE) begin
                rd_byte = 8'h00;
            end else if (RD_IDX >= DG_LEN) begin
                rd_bad = 1'b1;
            end else begin
                unique case (RD_IDX)
                    DG_SUMMARY:  rd_byte = summary_q;
                    DG_MODINFO:  rd_byte = MODULE_INFO_VAL;
                    DG_RSV_C:    rd_byte = 8'h00;
                    DG_INTERNAL: rd_byte = 8'h00;
                    DG_CHKIND:   rd_byte = CHANNEL_KIND;
                    DG_BITS_CH:  rd_byte = DIAG_BITS_VAL;
                    DG_CH_CNT:   rd_byte = CHANNEL_CNT_VAL;
                    DG_CH_SUM:   rd_byte = {4'h0, ch_sum_q};
                    default:     rd_byte = 8'h00;
                endcase
            end
        end else if (RD_REC >= REC_RANGE_BASE && RD_REC < REC_RANGE_BASE + 8'(NUM_CH) &&
                     RD_IDX == PAR_IDX_RANGE) begin
            rd_byte = range_q[RD_REC[1:0]];
        end else begin
            rd_bad = 1'b1;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RD_DATA  <= 8'h00;
            RD_VALID <= 1'b0;
            RD_ERR   <= 1'b0;
        end else begin
            RD_VALID <= RD_STB;
            RD_DATA  <= RD_STB ? rd_byte : 8'h00;
            RD_ERR   <= RD_STB && rd_bad;
        end
    end

    // checks
    sequence s_wbe_write;
        WR_STB && WR_REC == REC_HEAD && WR_IDX == PAR_IDX_WBE;
    endsequence

    property p_wbe_write;
        @(posedge MCLK) disable iff (!RST_N) s_wbe_write |=> wbe_q == $past(WR_DATA[3:0]);
    endproperty
    a_wbe_write: assert property (p_wbe_write) else $error("wire-break enable not stored");

    property p_deactivate;
        @(posedge MCLK) disable iff (!RST_N)
            range_q[0] == RNG_OFF [*2] |=> CH_CURRENT_UA[0] == 16'h0000 && !CH_ACTIVE[0];
    endproperty
    a_deactivate: assert property (p_deactivate) else $error("deactivated channel still drives");

    property p_full_scale;
        @(posedge MCLK) disable iff (!RST_N)
            range_q[0] == RNG_0_20_NEW && CH_VALUE[0] == 16'd27648 |=> CH_CURRENT_UA[0] == 16'd20000;
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not 20 mA");

    property p_clamp;
        @(posedge MCLK) disable iff (!RST_N)
            range_q[1] == RNG_0_20_OLD && CH_VALUE[1][15] |=> CH_CURRENT_UA[1] == 16'h0000;
    endproperty
    a_clamp: assert property (p_clamp) else $error("negative value not clamped");

    property p_led;
        @(posedge MCLK) disable iff (!RST_N)
            ##1 CH_ERR_LED[2] == ($past(!range_ok(range_q[2])) ||
                                  $past(wbe_q[2] && wb_s2_q[2] && range_q[2] != RNG_OFF));
    endproperty
    a_led: assert property (p_led) else $error("channel LED disagrees with error byte");

    sequence s_aux_lost;
        !AUX_OK_RAW [*4];
    endsequence

    property p_aux;
        @(posedge MCLK) disable iff (!RST_N) s_aux_lost |-> summary_q[SUM_AUX] && summary_q[SUM_EXTERNAL];
    endproperty
    a_aux: assert property (p_aux) else $error("aux loss not reported");

    property p_head_limit;
        @(posedge MCLK) disable iff (!RST_N)
            RD_STB && RD_REC == REC_HEAD && RD_IDX >= DG_HEAD_LEN |=> RD_VALID && RD_ERR && RD_DATA == 8'h00;
    endproperty
    a_head_limit: assert property (p_head_limit) else $error("record 00h read past its head");

    property p_param_sum;
        @(posedge MCLK) disable iff (!RST_N)
            ##1 summary_q[SUM_PARAM] == $past(!(range_ok(range_q[0]) && range_ok(range_q[1]) &&
                                                range_ok(range_q[2]) && range_ok(range_q[3])));
    endproperty
    a_param_sum: assert property (p_param_sum) else $error("parameter summary bit wrong");

    property p_chkind;
        @(posedge MCLK) disable iff (!RST_N) RD_STB && RD_REC == REC_DIAG && RD_IDX == DG_CHKIND |=> RD_DATA == 8'h73;
    endproperty
    a_chkind: assert property (p_chkind) else $error("channel kind byte wrong");

    property p_clear;
        @(posedge MCLK) disable iff (!RST_N)
            range_q[3] == RNG_OFF [*2] ##1 !aux_s2_q == 1'b0 |-> ch_err_q[3] == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("stale error on deactivated channel");

    property p_tick;
        @(posedge MCLK) disable iff (!RST_N)
            us_div_q == 6'(US_CYCLES - 1) |=> us_q == $past(us_q) + 32'h00000001 && us_div_q == 6'h00;
    endproperty
    a_tick: assert property (p_tick) else $error("microsecond counter misstep");

endmodule

// File: hdl/cpdg_pkg.sv
/*
 * Constants for the parameter and diagnostic logic of the four-channel
 * current-output module: record numbers, byte layout, field positions,
 * reset values, range codes and timing.
 * Assumes a single 50 MHz clock; the package itself holds no logic.
 */
package cpdg_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // record numbers
    localparam logic [7:0] REC_HEAD       = 8'h00;  // write: parameters, read: diag head
    localparam logic [7:0] REC_DIAG       = 8'h01;
    localparam logic [7:0] REC_RANGE_BASE = 8'h80;  // 80h..83h, one per channel

    // parameter record byte positions
    localparam logic [4:0] PAR_IDX_WBE   = 5'h01;
    localparam logic [4:0] PAR_IDX_RANGE = 5'h00;

    // diagnostic record byte positions
    localparam logic [4:0] DG_SUMMARY  = 5'h00;
    localparam logic [4:0] DG_MODINFO  = 5'h01;
    localparam logic [4:0] DG_RSV_C    = 5'h02;
    localparam logic [4:0] DG_INTERNAL = 5'h03;
    localparam logic [4:0] DG_CHKIND   = 5'h04;
    localparam logic [4:0] DG_BITS_CH  = 5'h05;
    localparam logic [4:0] DG_CH_CNT   = 5'h06;
    localparam logic [4:0] DG_CH_SUM   = 5'h07;
    localparam logic [4:0] DG_CH_BASE  = 5'h08;
    localparam logic [4:0] DG_RSV_BASE = 5'h0C;
    localparam logic [4:0] DG_TS_BASE  = 5'h10;
    localparam logic [4:0] DG_LEN      = 5'h14;
    localparam logic [4:0] DG_HEAD_LEN = 5'h04;

    // constant descriptive bytes and reset values
    localparam logic [7:0] MODULE_INFO_VAL = 8'h15;
    localparam logic [7:0] CHANNEL_KIND    = 8'h73;
    localparam logic [7:0] DIAG_BITS_VAL   = 8'h08;
    localparam logic [7:0] CHANNEL_CNT_VAL = 8'h04;
    localparam logic [7:0] WBE_RST         = 8'h00;
    localparam logic [7:0] RANGE_RST       = 8'h31;
    localparam logic [3:0] WBE_FIELD_MASK  = 4'hF;

    // summary byte bit positions
    localparam int SUM_MODFAIL  = 0;
    localparam int SUM_INTERNAL = 1;
    localparam int SUM_EXTERNAL = 2;
    localparam int SUM_CHANNEL  = 3;
    localparam int SUM_AUX      = 4;
    localparam int SUM_PARAM    = 7;

    // per-channel error byte bit positions
    localparam int CHE_PARAM = 0;
    localparam int CHE_WIRE  = 4;

    // range codes
    typedef enum logic [7:0] {
        RNG_4_20_NEW = 8'h30,
        RNG_0_20_NEW = 8'h31,
        RNG_4_20_OLD = 8'h40,
        RNG_0_20_OLD = 8'h41,
        RNG_OFF      = 8'hFF
    } cpdg_range_t;

    // scaling, current in microamps
    localparam int FULL_NEW     = 27648;
    localparam int FULL_OLD     = 16384;
    localparam int SPAN_0_20_UA = 20000;
    localparam int SPAN_4_20_UA = 16000;
    localparam int ZERO_4_20_UA = 4000;

endpackage

// File: bench/cpdg_host.sv
/*
 * Controller model for the record port: single-byte record writes and
 * reads, and the signed channel values.
 * Assumes the core takes strobes on rising MCLK and answers a read one
 * cycle later; this model changes its outputs on the falling edge.
 */
`timescale 1ns/1ps
module cpdg_host (
    input  wire logic        MCLK,
    input  wire logic [7:0]  RD_DATA,
    input  wire logic        RD_VALID,
    input  wire logic        RD_ERR,
    output logic             WR_STB,
    output logic [7:0]       WR_REC,
    output logic [4:0]       WR_IDX,
    output logic [7:0]       WR_DATA,
    output logic             RD_STB,
    output logic [7:0]       RD_REC,
    output logic [4:0]       RD_IDX,
    output logic [3:0][15:0] CH_VALUE
);
    // quiet port at time zero
    initial begin
        {WR_STB, WR_REC, WR_IDX, WR_DATA} = '0;
        {RD_STB, RD_REC, RD_IDX} = '0;
        CH_VALUE = '0;
    end

    // one byte per strobe; released lines are scrambled so stale values never pass
    task automatic wr(input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] dat);
        @(negedge MCLK);
        {WR_STB, WR_REC, WR_IDX, WR_DATA} = {1'b1, rec, idx, dat};
        @(negedge MCLK);
        {WR_STB, WR_REC, WR_IDX, WR_DATA} = {1'b0, ~rec, ~idx, ~dat};
    endtask

    // answer is sampled in the cycle after the strobe edge; head reads use 0..3
    task automatic rd(input logic [7:0] rec, input logic [4:0] idx, output logic [7:0] dat,
                      output logic err, output logic vld);
        @(negedge MCLK);
        {RD_STB, RD_REC, RD_IDX} = {1'b1, rec, idx};
        @(negedge MCLK);
        {vld, err, dat} = {RD_VALID, RD_ERR, RD_DATA};
        {RD_STB, RD_REC, RD_IDX} = {1'b0, ~rec, ~idx};
    endtask

    // values of 100 or more keep wire-break detection reliable
    task automatic set_val(input int c, input logic [15:0] v);
        @(negedge MCLK);
        CH_VALUE[c] = v;
    endtask
endmodule

// File: bench/testbench.sv
/*
 * Self-checking bench for the current-output parameter and diagnostic
 * core: scaling, deactivation, record layout, wire-break, supply loss.
 * Assumes cpdg_pkg, cpdg_core and the cpdg_host controller model.
 */
`timescale 1ns/1ps
module testbench;
    import cpdg_pkg::*;
    localparam int TEST_NS = 4000 * CLK_PERIOD_NS;
    logic              MCLK = 1'b0;
    logic              RST_N, AUX_OK_RAW, WR_STB, RD_STB, RD_VALID, RD_ERR, e, v;
    logic [3:0]        WIRE_BREAK_RAW, CH_ACTIVE, CH_ERR_LED;
    logic [7:0]        WR_REC, RD_REC, WR_DATA, RD_DATA, d, code;
    logic [4:0]        WR_IDX, RD_IDX;
    logic [3:0][15:0]  CH_VALUE, CH_CURRENT_UA;
    logic [15:0]       val;
    logic [31:0]       ts, ts0;
    integer            seed = 99326;
    int                failures = 0;
    int                cmp_count = 0;
    int                c;
    logic [7:0]        codes[5] = '{8'h30, 8'h31, 8'h40, 8'h41, 8'hFF};
    logic [15:0]       corners[8] = '{16'h0000, 16'hFFFF, 16'h0064, 16'h6C00, 16'h4000, 16'h7FFF, 16'hE500, 16'h8000};

    always #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;

    cpdg_core cpdg_core_i (.MCLK(MCLK), .RST_N(RST_N), .WR_STB(WR_STB), .WR_REC(WR_REC), .WR_IDX(WR_IDX),
        .WR_DATA(WR_DATA), .RD_STB(RD_STB), .RD_REC(RD_REC), .RD_IDX(RD_IDX), .CH_VALUE(CH_VALUE),
        .WIRE_BREAK_RAW(WIRE_BREAK_RAW), .AUX_OK_RAW(AUX_OK_RAW), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .RD_ERR(RD_ERR), .CH_CURRENT_UA(CH_CURRENT_UA), .CH_ACTIVE(CH_ACTIVE), .CH_ERR_LED(CH_ERR_LED));
    cpdg_host cpdg_host_i (.MCLK(MCLK), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_ERR(RD_ERR),
        .WR_STB(WR_STB), .WR_REC(WR_REC), .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .RD_STB(RD_STB),
        .RD_REC(RD_REC), .RD_IDX(RD_IDX), .CH_VALUE(CH_VALUE));

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // current in microamps; integer divide truncates toward zero, negatives floor at zero
    function automatic logic [15:0] exp_cur(input logic [7:0] cd, input logic [15:0] x);
        int s, f, r;
        s = $signed(x);
        f = (cd == 8'h40 || cd == 8'h41) ? 16384 : 27648;
        case (cd)
            8'h31, 8'h41: r = s * 20000 / f;
            8'h30, 8'h40: r = 4000 + s * 16000 / f;
            default: r = 0;
        endcase
        return (r < 0) ? 16'h0000 : r[15:0];
    endfunction

    // diagnostic byte i from the four channel error bytes and supply state
    function automatic logic [7:0] exp_byte(input int i, input logic [31:0] chb, input logic aux);
        logic w, p;
        w = chb[4] | chb[12] | chb[20] | chb[28];
        p = chb[0] | chb[8] | chb[16] | chb[24];
        case (i)
            0: return {p, 2'b00, aux, |chb, w | aux, 1'b0, (|chb) | w | aux};
            1: return 8'h15;
            4: return 8'h73;
            5: return 8'h08;
            6: return 8'h04;
            7: return {4'h0, |chb[31:24], |chb[23:16], |chb[15:8], |chb[7:0]};
            8, 9, 10, 11: return chb[(i - 8) * 8 +: 8];
            default: return 8'h00;
        endcase
    endfunction

    task automatic check_diag(input logic [31:0] chb, input logic aux, input int n);
        for (int i = 0; i < n; i++) begin
            cpdg_host_i.rd(REC_DIAG, 5'(i), d, e, v);
            check(32'({v, e, d}), 32'({2'b10, exp_byte(i, chb, aux)}));
        end
    endtask

    // timestamp bytes arrive low byte first
    task automatic read_ts(output logic [31:0] t);
        for (int i = 0; i < 4; i++) begin
            cpdg_host_i.rd(REC_DIAG, 5'(16 + i), d, e, v);
            t[i * 8 +: 8] = d;
        end
    endtask

    // a hang counts as a mismatch and ends the run the normal way
    initial begin
        #(TEST_NS * 5);
        failures++;
        results();
    end

    initial begin
        RST_N = 1'b0;
        WIRE_BREAK_RAW = 4'h0;
        AUX_OK_RAW = 1'b1;
        repeat (3) @(negedge MCLK);
        check(32'(CH_ACTIVE), 32'h0);
        RST_N = 1'b1;
        @(negedge MCLK);
        check(32'(CH_ACTIVE), 32'hF);
        check_diag(32'h0, 1'b0, 20);
        for (int i = 0; i < 5; i++) begin
            cpdg_host_i.rd(REC_HEAD, 5'(i), d, e, v);
            check(32'({v, e, d}), 32'({1'b1, i == 4, (i == 4) ? 8'h00 : exp_byte(i, 0, 0)}));
        end
        cpdg_host_i.rd(8'h02, 5'h00, d, e, v);
        check(32'({v, e, d}), 32'h300);
        $display("test reset and layout done");
        // every code on every channel; corner values first, then random ones
        for (int n = 0; n < 24; n++) begin
            c = n % 4;
            code = codes[n % 5];
            val = (n < 8) ? corners[n] : 16'($random(seed));
            cpdg_host_i.set_val(c, val);
            cpdg_host_i.wr(REC_RANGE_BASE + 8'(c), 5'h00, code);
            repeat (2) @(negedge MCLK);
            check(32'(CH_CURRENT_UA[c]), 32'(exp_cur(code, val)));
            check(32'(CH_ACTIVE[c]), 32'(code != 8'hFF));
            cpdg_host_i.rd(REC_RANGE_BASE + 8'(c), 5'h00, d, e, v);
            check(32'(d), 32'(code));
        end
        for (int i = 0; i < 4; i++) begin
            cpdg_host_i.wr(REC_RANGE_BASE + 8'(i), 5'h00, 8'h31);
        end
        // hand corners: nominal full scale on channel 0, most negative value in the older format on channel 1
        cpdg_host_i.wr(REC_RANGE_BASE + 8'h01, 5'h00, 8'h41);
        cpdg_host_i.set_val(0, 16'h6C00);
        cpdg_host_i.set_val(1, 16'h8000);
        repeat (2) @(negedge MCLK);
        check(32'(CH_CURRENT_UA[0]), 32'(exp_cur(8'h31, 16'h6C00)));
        check(32'(CH_CURRENT_UA[1]), 32'(exp_cur(8'h41, 16'h8000)));
        $display("test ranges done");
        cpdg_host_i.wr(REC_RANGE_BASE + 8'h02, 5'h00, 8'h55);
        repeat (3) @(negedge MCLK);
        check(32'(CH_ERR_LED), 32'h4);
        check_diag(32'h00010000, 1'b0, 16);
        read_ts(ts0);
        check(32'(ts0 != 0), 32'h1);
        cpdg_host_i.wr(REC_RANGE_BASE + 8'h02, 5'h00, 8'h31);
        repeat (3) @(negedge MCLK);
        check(32'(CH_ERR_LED), 32'h0);
        check_diag(32'h0, 1'b0, 16);
        read_ts(ts);
        check(ts, ts0);
        $display("test parameter error done");
        for (int i = 0; i < 4; i++) begin
            cpdg_host_i.set_val(i, 16'h0064);
        end
        // channel 0 switched off: its break must stay silent
        cpdg_host_i.wr(REC_RANGE_BASE, 5'h00, 8'hFF);
        cpdg_host_i.wr(REC_HEAD, PAR_IDX_WBE, 8'hF5);
        WIRE_BREAK_RAW = 4'hF;
        repeat (4) @(negedge MCLK);
        check(32'(CH_ERR_LED), 32'h4);
        check_diag(32'h00100000, 1'b0, 16);
        cpdg_host_i.wr(REC_RANGE_BASE, 5'h00, 8'h31);
        repeat (3) @(negedge MCLK);
        check(32'(CH_ERR_LED), 32'h5);
        WIRE_BREAK_RAW = 4'h0;
        repeat (4) @(negedge MCLK);
        check(32'(CH_ERR_LED), 32'h0);
        $display("test wire break done");
        AUX_OK_RAW = 1'b0;
        repeat (4) @(negedge MCLK);
        check_diag(32'h0, 1'b1, 8);
        AUX_OK_RAW = 1'b1;
        repeat (4) @(negedge MCLK);
        check_diag(32'h0, 1'b0, 1);
        $display("test aux supply done");
        results();
    end
endmodule
